// [hw/axfe_consts.svh]
// Constants of the axis feedback and event block
// Assumes inclusion by bare name from the package and the design files
`ifndef AXFE_CONSTS_SVH
`define AXFE_CONSTS_SVH

// Event bank and event source parameter numbers
`define AXFE_BANK_EVENT    8'h03
`define AXFE_GP_TIMER_A    8'h00
`define AXFE_GP_TIMER_B    8'h01
`define AXFE_GP_TIMER_C    8'h02
`define AXFE_GP_LEFT       8'h1B
`define AXFE_GP_RIGHT      8'h1C
`define AXFE_GP_IN_A       8'h27
`define AXFE_GP_IN_B       8'h28
`define AXFE_GP_IN_C       8'h29

// Axis parameter numbers
`define AXFE_AP_MICROSTEP  8'h8C
`define AXFE_AP_ENC_POS    8'hD1
`define AXFE_AP_NULL_CLR   8'hD2
`define AXFE_AP_ENC_MAXDEV 8'hD4
`define AXFE_AP_ENC_ABS    8'hD7
`define AXFE_AP_EXT_POS    8'hD8
`define AXFE_AP_EXT_CPR    8'hD9
`define AXFE_AP_EXT_MAXDEV 8'hDA
`define AXFE_AP_SD_MODE    8'hFE

// Microstep code: 2**code microsteps per full step
`define AXFE_MS_RESET      4'h8
`define AXFE_MS_MAX        4'h8

// Resolution figures
`define AXFE_FULLSTEPS     48'h0000000000C8
`define AXFE_MAG_MAX       10'h3FF
`define AXFE_MAG_NULL      10'h000
`define AXFE_PRE_SHIFT     6'h06
`define AXFE_FRAC_SHIFT    6'h10

// Edge selector codes
`define AXFE_EDGE_OFF      2'h0
`define AXFE_EDGE_RISE     2'h1
`define AXFE_EDGE_FALL     2'h2
`define AXFE_EDGE_BOTH     2'h3

// Timer base
`define AXFE_MS_NS         1000000
`define AXFE_CLK_NS        20

`endif

// [hw/axfe_pkg.sv]
// Types shared by the axis feedback and event block
// Assumes the constants header sits beside it
package axfe_pkg;
  `include "axfe_consts.svh"

  // Host command operations
  typedef enum logic [2:0] {
    set_global_parameter_cmd,
    get_axis_parameter_cmd,
    set_axis_parameter_cmd,
    rotate_left_cmd,
    rotate_right_cmd,
    motor_stop_cmd,
    move_to_position_cmd
  } axfe_op_t;
endpackage : axfe_pkg

// [hw/axfe_period_timer.sv]
// One periodic event source counting millisecond ticks
// Assumes a one-cycle millisecond tick from the parent
`timescale 1ns/100ps
module axfe_period_timer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Tick and period
  input  wire logic        ms_tick_i,
  input  wire logic [31:0] period_i,
  // Event pulse
  output logic             fire_o
);
  logic [31:0] ms_count;
  wire  logic  period_end;

  // End of interval; a period of zero never fires
  assign period_end = (period_i != 32'h0) && ms_tick_i && (ms_count >= period_i - 32'h1);

  // Interval counter in milliseconds
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ms_count <= 32'h0;
      fire_o   <= 1'b0;
    end else begin
      fire_o <= period_end;
      if (period_i == 32'h0 || period_end) begin
        ms_count <= 32'h0;
      end else if (ms_tick_i) begin
        ms_count <= ms_count + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_fire_on_tick;
    fire_o |-> ($past(ms_tick_i) && $past(period_i) != 32'h0 && ms_count == 32'h0);
  endproperty
  a_fire_on_tick: assert property (p_fire_on_tick) else $error("timer fired off a tick");
endmodule : axfe_period_timer

// [hw/axfe_core.sv]
// Axis feedback and event logic: encoder counters, deviation stop,
// step/direction mode and prioritised event sources.
// Assumes all inputs synchronous to clk_i and one command per cycle at most.
`timescale 1ns/100ps
`include "axfe_consts.svh"
module axfe_core #(
  parameter int unsigned MS_CYCLES = `AXFE_MS_NS / `AXFE_CLK_NS
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Host parameter commands
  input  wire logic              cmd_valid_i,
  input  wire axfe_pkg::axfe_op_t cmd_op_i,
  input  wire logic [7:0]        cmd_type_i,
  input  wire logic [7:0]        cmd_bank_i,
  input  wire logic [31:0]       cmd_value_i,
  output logic                   reply_valid_o,
  output logic                   reply_ok_o,
  output logic [31:0]            reply_value_o,
  // Sensors
  input  wire logic [9:0]        mag_angle_i,
  input  wire logic              enc_a_i,
  input  wire logic              enc_b_i,
  input  wire logic [31:0]       motor_pos_i,
  input  wire logic              left_limit_i,
  input  wire logic              right_limit_i,
  input  wire logic [2:0]        gp_in_i,
  input  wire logic              step_i,
  input  wire logic              dir_i,
  // Motion side
  output logic                   motion_valid_o,
  output axfe_pkg::axfe_op_t     motion_op_o,
  output logic [31:0]            motion_value_o,
  output logic                   step_o,
  output logic                   dir_o,
  output logic [3:0]             microstep_res_o,
  output logic                   deviation_stop_o,
  // Events
  output logic                   event_valid_o,
  output logic [7:0]             event_num_o,
  input  wire logic              event_ack_i
);
  // Configuration state
  logic [31:0]        timer_period [0:2];
  logic [1:0]         edge_sel [0:4];
  logic [31:0]        enc_maxdev;
  logic [31:0]        ext_maxdev;
  logic [31:0]        ext_cpr;
  logic               null_armed;
  logic               sd_mode;
  // Counters and samples
  logic signed [47:0] int_acc;
  logic signed [47:0] ext_acc;
  logic [31:0]        int_pre;
  logic [31:0]        ext_pre;
  logic [9:0]         mag_prev;
  logic               mag_seen;
  logic               enc_a_prev;
  logic               enc_b_prev;
  logic [4:0]         edge_prev;
  logic [15:0]        ms_count;
  logic               ms_tick;
  logic [7:0]         pending;
  logic [2:0]         event_idx;

  // Source number of each pending slot, slot 0 has the highest priority
  function automatic logic [7:0] src_num(input logic [2:0] idx);
    unique case (idx)
      3'h0: src_num = `AXFE_GP_TIMER_A;
      3'h1: src_num = `AXFE_GP_TIMER_B;
      3'h2: src_num = `AXFE_GP_TIMER_C;
      3'h3: src_num = `AXFE_GP_LEFT;
      3'h4: src_num = `AXFE_GP_RIGHT;
      3'h5: src_num = `AXFE_GP_IN_A;
      3'h6: src_num = `AXFE_GP_IN_B;
      3'h7: src_num = `AXFE_GP_IN_C;
    endcase
  endfunction : src_num

  // Edge match against a selector code
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    edge_hit = (sel[0] && !prev && cur) || (sel[1] && prev && !cur);
  endfunction : edge_hit

  // Command decode
  wire logic cmd_sgp  = cmd_valid_i && cmd_op_i == axfe_pkg::set_global_parameter_cmd;
  wire logic cmd_sap  = cmd_valid_i && cmd_op_i == axfe_pkg::set_axis_parameter_cmd;
  wire logic cmd_gap  = cmd_valid_i && cmd_op_i == axfe_pkg::get_axis_parameter_cmd;
  wire logic cmd_move = cmd_valid_i && !cmd_sgp && !cmd_sap && !cmd_gap;
  wire logic gp_wr    = cmd_sgp && cmd_bank_i == `AXFE_BANK_EVENT;
  wire logic wr_ms    = cmd_sap && cmd_type_i == `AXFE_AP_MICROSTEP
                        && cmd_value_i <= 32'(`AXFE_MS_MAX);
  wire logic wr_enc   = cmd_sap && cmd_type_i == `AXFE_AP_ENC_POS;
  wire logic wr_null  = cmd_sap && cmd_type_i == `AXFE_AP_NULL_CLR;
  wire logic wr_ext   = cmd_sap && cmd_type_i == `AXFE_AP_EXT_POS;

  // Event source inputs: limit switches and general inputs
  wire logic [4:0] edge_in = {gp_in_i, right_limit_i, left_limit_i};
  wire logic [7:0] event_set;
  wire logic [7:0] event_clr;
  wire logic [7:0] next_pending;
  logic      [2:0] next_idx;

  // Timers on a millisecond base
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_timer
      axfe_period_timer u_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ms_tick_i (ms_tick),
        .period_i  (timer_period[gi]),
        .fire_o    (event_set[gi])
      );
    end
    for (gi = 0; gi < 5; gi++) begin : g_edge
      assign event_set[gi+3] = edge_hit(edge_sel[gi], edge_prev[gi], edge_in[gi]);
    end
  endgenerate

  // Pending set wins over acknowledge; lowest slot is presented
  assign event_clr    = (event_valid_o && event_ack_i) ? (8'h01 << event_idx) : 8'h00;
  assign next_pending = (pending & ~event_clr) | event_set;
  always_comb begin
    next_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (next_pending[i]) next_idx = 3'(i);
    end
  end

  // Magnetic encoder step scaled to microsteps, 16 fraction bits
  wire logic signed [9:0]  mag_delta = $signed(mag_angle_i - mag_prev);
  wire logic signed [47:0] int_step  = 48'($signed(mag_delta)) * 48'($signed({1'b0, int_pre}));
  wire logic               at_null   = mag_angle_i == `AXFE_MAG_NULL;

  // Quadrature: one phase changed, direction from phase order
  wire logic quad_move = (enc_a_i ^ enc_a_prev) ^ (enc_b_i ^ enc_b_prev);
  wire logic quad_up   = ~(enc_a_prev ^ enc_b_i);
  wire logic signed [47:0] ext_step = $signed({16'h0, ext_pre});

  // Deviation between motor and encoder positions
  wire logic [31:0] int_pos  = int_acc[47:16];
  wire logic [31:0] ext_pos  = ext_acc[47:16];
  wire logic signed [32:0] int_diff = $signed({motor_pos_i[31], motor_pos_i})
                                      - $signed({int_pos[31], int_pos});
  wire logic signed [32:0] ext_diff = $signed({motor_pos_i[31], motor_pos_i})
                                      - $signed({ext_pos[31], ext_pos});
  wire logic [32:0] int_abs = int_diff[32] ? 33'(-int_diff) : 33'(int_diff);
  wire logic [32:0] ext_abs = ext_diff[32] ? 33'(-ext_diff) : 33'(ext_diff);
  wire logic int_exceed = enc_maxdev != 32'h0 && int_abs > {1'b0, enc_maxdev};
  wire logic ext_exceed = ext_maxdev != 32'h0 && ext_abs > {1'b0, ext_maxdev};

  // Prescalers
  wire logic [47:0] int_pre_full = `AXFE_FULLSTEPS << (6'(microstep_res_o) + `AXFE_PRE_SHIFT);
  wire logic [47:0] ext_num      = `AXFE_FULLSTEPS << (6'(microstep_res_o) + `AXFE_FRAC_SHIFT);
  wire logic [47:0] ext_quot     = (ext_cpr == 32'h0) ? 48'h0 : ext_num / {16'h0, ext_cpr};

  // Axis parameter read selection
  logic [31:0] rd_value;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (cmd_type_i)
      `AXFE_AP_MICROSTEP:  rd_value = {28'h0, microstep_res_o};
      `AXFE_AP_ENC_POS:    rd_value = int_pos;
      `AXFE_AP_NULL_CLR:   rd_value = {31'h0, null_armed};
      `AXFE_AP_ENC_MAXDEV: rd_value = enc_maxdev;
      `AXFE_AP_ENC_ABS:    rd_value = {22'h0, mag_angle_i & `AXFE_MAG_MAX};
      `AXFE_AP_EXT_POS:    rd_value = ext_pos;
      `AXFE_AP_EXT_CPR:    rd_value = ext_cpr;
      `AXFE_AP_EXT_MAXDEV: rd_value = ext_maxdev;
      `AXFE_AP_SD_MODE:    rd_value = {31'h0, sd_mode};
      default: begin
        rd_value = 32'h0;
        rd_ok    = 1'b0;
      end
    endcase
  end

  // Write acceptance
  wire logic sap_ok = wr_ms || wr_enc || wr_null || wr_ext
                      || (cmd_sap && cmd_type_i inside {`AXFE_AP_ENC_MAXDEV, `AXFE_AP_EXT_CPR,
                          `AXFE_AP_EXT_MAXDEV, `AXFE_AP_SD_MODE});
  wire logic sgp_ok = gp_wr && cmd_type_i inside {`AXFE_GP_TIMER_A, `AXFE_GP_TIMER_B,
                      `AXFE_GP_TIMER_C, `AXFE_GP_LEFT, `AXFE_GP_RIGHT, `AXFE_GP_IN_A,
                      `AXFE_GP_IN_B, `AXFE_GP_IN_C};

  // Millisecond tick
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ms_count <= 16'h0;
      ms_tick  <= 1'b0;
    end else begin
      ms_tick  <= ms_count == 16'(MS_CYCLES - 1);
      ms_count <= (ms_count == 16'(MS_CYCLES - 1)) ? 16'h0 : ms_count + 16'h1;
    end
  end

  // Event source configuration over bank 3
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 3; i++) timer_period[i] <= 32'h0;
      for (int i = 0; i < 5; i++) edge_sel[i] <= `AXFE_EDGE_OFF;
    end else if (sgp_ok) begin
      unique case (cmd_type_i)
        `AXFE_GP_TIMER_A: timer_period[0] <= cmd_value_i;
        `AXFE_GP_TIMER_B: timer_period[1] <= cmd_value_i;
        `AXFE_GP_TIMER_C: timer_period[2] <= cmd_value_i;
        `AXFE_GP_LEFT:    edge_sel[0] <= cmd_value_i[1:0];
        `AXFE_GP_RIGHT:   edge_sel[1] <= cmd_value_i[1:0];
        `AXFE_GP_IN_A:    edge_sel[2] <= cmd_value_i[1:0];
        `AXFE_GP_IN_B:    edge_sel[3] <= cmd_value_i[1:0];
        default:          edge_sel[4] <= cmd_value_i[1:0];
      endcase
    end
  end

  // Axis configuration
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      microstep_res_o <= `AXFE_MS_RESET;
      enc_maxdev      <= 32'h0;
      ext_maxdev      <= 32'h0;
      ext_cpr         <= 32'h0;
      sd_mode         <= 1'b0;
    end else if (cmd_sap) begin
      if (wr_ms) microstep_res_o <= cmd_value_i[3:0];
      if (cmd_type_i == `AXFE_AP_ENC_MAXDEV) enc_maxdev <= cmd_value_i;
      if (cmd_type_i == `AXFE_AP_EXT_MAXDEV) ext_maxdev <= cmd_value_i;
      if (cmd_type_i == `AXFE_AP_EXT_CPR) ext_cpr <= cmd_value_i;
      if (cmd_type_i == `AXFE_AP_SD_MODE) sd_mode <= cmd_value_i == 32'h1;
    end
  end

  // Prescalers track the current microstep and counts settings
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_pre <= 32'h0;
      ext_pre <= 32'h0;
    end else begin
      int_pre <= int_pre_full[31:0];
      ext_pre <= ext_quot[31:0];
    end
  end

  // Integrated encoder counter with load and clear-on-null
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_acc    <= 48'sh0;
      mag_prev   <= 10'h0;
      mag_seen   <= 1'b0;
      null_armed <= 1'b0;
    end else begin
      mag_prev <= mag_angle_i;
      mag_seen <= 1'b1;
      if (wr_enc) begin
        int_acc <= $signed({cmd_value_i, 16'h0});
      end else if (null_armed && at_null) begin
        int_acc <= 48'sh0;
      end else if (mag_seen) begin
        int_acc <= int_acc + int_step;
      end
      if (wr_null) begin
        null_armed <= cmd_value_i == 32'h1;
      end else if (at_null) begin
        null_armed <= 1'b0;
      end
    end
  end

  // External quadrature counter
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_acc    <= 48'sh0;
      enc_a_prev <= 1'b0;
      enc_b_prev <= 1'b0;
    end else begin
      enc_a_prev <= enc_a_i;
      enc_b_prev <= enc_b_i;
      if (wr_ext) begin
        ext_acc <= $signed({cmd_value_i, 16'h0});
      end else if (quad_move) begin
        ext_acc <= quad_up ? ext_acc + ext_step : ext_acc - ext_step;
      end
    end
  end

  // Deviation stop, motion gating and step/direction pass-through
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      deviation_stop_o <= 1'b0;
      motion_valid_o   <= 1'b0;
      motion_op_o      <= axfe_pkg::motor_stop_cmd;
      motion_value_o   <= 32'h0;
      step_o           <= 1'b0;
      dir_o            <= 1'b0;
    end else begin
      deviation_stop_o <= int_exceed || ext_exceed;
      motion_valid_o   <= cmd_move && !sd_mode;
      if (cmd_move) begin
        motion_op_o    <= cmd_op_i;
        motion_value_o <= cmd_value_i;
      end
      step_o <= sd_mode && step_i;
      dir_o  <= sd_mode && dir_i;
    end
  end

  // Replies and event presentation
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reply_valid_o <= 1'b0;
      reply_ok_o    <= 1'b0;
      reply_value_o <= 32'h0;
      pending       <= 8'h0;
      edge_prev     <= 5'h0;
      event_idx     <= 3'h0;
      event_valid_o <= 1'b0;
      event_num_o   <= 8'h0;
    end else begin
      reply_valid_o <= cmd_valid_i;
      reply_ok_o    <= (cmd_gap && rd_ok) || sap_ok || sgp_ok || (cmd_move && !sd_mode);
      reply_value_o <= cmd_gap ? rd_value : 32'h0;
      pending       <= next_pending;
      edge_prev     <= edge_in;
      event_idx     <= next_idx;
      event_valid_o <= |next_pending;
      event_num_o   <= src_num(next_idx);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_get_abs;
    cmd_gap && cmd_type_i == `AXFE_AP_ENC_ABS;
  endsequence
  sequence s_abs_reply;
    reply_valid_o && reply_ok_o && reply_value_o <= 32'h3FF;
  endsequence

  property p_prio_lowest;
    event_valid_o |-> (pending & ((8'h01 << event_idx) - 8'h01)) == 8'h00;
  endproperty
  a_prio_lowest: assert property (p_prio_lowest) else $error("lower source left waiting");

  property p_left_rise;
    (edge_sel[0] == `AXFE_EDGE_RISE && $rose(left_limit_i)) |=> pending[3];
  endproperty
  a_left_rise: assert property (p_left_rise) else $error("left rising edge lost");

  property p_enc_load;
    wr_enc |=> int_pos == $past(cmd_value_i);
  endproperty
  a_enc_load: assert property (p_enc_load) else $error("encoder load failed");

  property p_null_clear;
    (null_armed && at_null && !cmd_sap) |=> (!null_armed && int_acc == 48'sh0);
  endproperty
  a_null_clear: assert property (p_null_clear) else $error("null clear missed");

  property p_dev_off;
    (enc_maxdev == 32'h0 && ext_maxdev == 32'h0) |=> !deviation_stop_o;
  endproperty
  a_dev_off: assert property (p_dev_off) else $error("stop with supervision off");

  property p_ext_dev;
    ext_exceed |=> deviation_stop_o;
  endproperty
  a_ext_dev: assert property (p_ext_dev) else $error("external deviation ignored");

  property p_abs_range;
    s_get_abs |=> s_abs_reply;
  endproperty
  a_abs_range: assert property (p_abs_range) else $error("absolute angle out of range");

  property p_sd_block;
    (sd_mode && cmd_move) |=> !motion_valid_o ##1 !motion_valid_o || $past(cmd_move);
  endproperty
  a_sd_block: assert property (p_sd_block) else $error("motion in step/dir mode");

  property p_ms_reset;
    $past(sys_rst_i) |-> microstep_res_o == `AXFE_MS_RESET;
  endproperty
  a_ms_reset: assert property (p_ms_reset) else $error("microstep reset wrong");

  property p_quad_up;
    (quad_move && quad_up && !wr_ext) |=> ext_acc == $past(ext_acc) + $past(ext_step);
  endproperty
  a_quad_up: assert property (p_quad_up) else $error("quadrature count wrong");
endmodule : axfe_core

// [bench/axfe_far_model.sv]
// Far-side model: external quadrature encoder and step/direction source
// Assumes the bench calls its tasks; every change follows a rising edge
`timescale 1ns/100ps
module axfe_far_model (
  // Clock
  input  wire logic clk_i,
  // Encoder phases and step/direction lines
  output logic      enc_a_o,
  output logic      enc_b_o,
  output logic      step_o,
  output logic      dir_o
);
  logic [1:0] phase;
  // Idle levels at time zero
  initial begin
    phase   = 2'h0;
    enc_a_o = 1'b0;
    enc_b_o = 1'b0;
    step_o  = 1'b0;
    dir_o   = 1'b0;
  end
  // Gray walk, one phase per step, A leading when counting up
  task automatic quad(input int n);
    for (int i = 0; i < (n < 0 ? -n : n); i++) begin
      phase = (n > 0) ? phase + 2'h1 : phase - 2'h1;
      @(posedge clk_i);
      enc_a_o <= phase[0] ^ phase[1];
      enc_b_o <= phase[1];
      @(posedge clk_i);
    end
  endtask : quad
  // One step pulse of one cycle with the direction set alongside
  task automatic pulse(input logic d);
    @(posedge clk_i);
    step_o <= 1'b1;
    dir_o  <= d;
    @(posedge clk_i);
    step_o <= 1'b0;
  endtask : pulse
endmodule : axfe_far_model

// [bench/tb_axfe_core.sv]
// Testbench for the axis feedback and event core
// Assumes the core with a 10-cycle millisecond and the far-side model
`timescale 1ns/100ps
module tb_axfe_core;
  localparam axfe_pkg::axfe_op_t SETA = axfe_pkg::set_axis_parameter_cmd;
  localparam axfe_pkg::axfe_op_t GETA = axfe_pkg::get_axis_parameter_cmd;
  localparam axfe_pkg::axfe_op_t SETG = axfe_pkg::set_global_parameter_cmd;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0, event_ack_i = 1'b0;
  axfe_pkg::axfe_op_t cmd_op_i = axfe_pkg::motor_stop_cmd;
  logic [7:0]  cmd_type_i = 8'h00, cmd_bank_i = 8'h00, event_num_o;
  logic [31:0] cmd_value_i = 32'h0, motor_pos_i = 32'h0, reply_value_o, motion_value_o;
  logic [9:0]  mag_angle_i = 10'h064;
  logic [2:0]  gp_in_i = 3'h1;
  logic        left_limit_i = 1'b0, right_limit_i = 1'b0;
  logic        enc_a, enc_b, step_in, dir_in, reply_valid_o, reply_ok_o, motion_valid_o;
  logic        step_o, dir_o, deviation_stop_o, event_valid_o;
  logic [3:0]  microstep_res_o;
  axfe_pkg::axfe_op_t motion_op_o;
  logic        r_ok;
  logic [31:0] r_val;
  int          miscompares = 0, n_tests = 0, cnt;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  axfe_core #(.MS_CYCLES(10)) i_axfe_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_type_i(cmd_type_i),
    .cmd_bank_i(cmd_bank_i), .cmd_value_i(cmd_value_i), .reply_valid_o(reply_valid_o),
    .reply_ok_o(reply_ok_o), .reply_value_o(reply_value_o), .mag_angle_i(mag_angle_i),
    .enc_a_i(enc_a), .enc_b_i(enc_b), .motor_pos_i(motor_pos_i),
    .left_limit_i(left_limit_i), .right_limit_i(right_limit_i), .gp_in_i(gp_in_i),
    .step_i(step_in), .dir_i(dir_in), .motion_valid_o(motion_valid_o),
    .motion_op_o(motion_op_o), .motion_value_o(motion_value_o), .step_o(step_o),
    .dir_o(dir_o), .microstep_res_o(microstep_res_o), .deviation_stop_o(deviation_stop_o),
    .event_valid_o(event_valid_o), .event_num_o(event_num_o), .event_ack_i(event_ack_i));
  axfe_far_model i_axfe_far_model (.clk_i(clk_i), .enc_a_o(enc_a), .enc_b_o(enc_b),
    .step_o(step_in), .dir_o(dir_in));
  // Compare seen against expected and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One host command; reply sampled in the cycle after it is taken
  task automatic cmd(input axfe_pkg::axfe_op_t op, input logic [7:0] t, input logic [7:0] b,
                     input logic [31:0] v);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i    <= op;
    cmd_type_i  <= t;
    cmd_bank_i  <= b;
    cmd_value_i <= v;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1;
    check(reply_valid_o, 1'b1);
    r_ok  = reply_ok_o;
    r_val = reply_value_o;
  endtask : cmd
  // Read an axis parameter and compare
  task automatic rd(input logic [7:0] t, input logic [31:0] exp);
    cmd(GETA, t, 8'h00, 32'h0);
    check(r_val, exp);
  endtask : rd
  // Consume the presented event
  task automatic ack;
    @(posedge clk_i);
    event_ack_i <= 1'b1;
    @(posedge clk_i);
    event_ack_i <= 1'b0;
    #1;
  endtask : ack
  // Wait a bounded time for a pending event, returning the cycles taken
  task automatic wait_ev(input int lim);
    cnt = 0;
    while (event_valid_o !== 1'b1 && cnt < lim) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
  endtask : wait_ev
  // Counts and verdict
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Watchdog against a hang
  initial begin
    #(20 * 20000);
    miscompares++;
    results();
  end
  // Test sequence
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    check(microstep_res_o, 4'h8);
    rd(8'hD7, 32'h64);
    mag_angle_i <= 10'h3FF;
    rd(8'hD7, 32'h3FF);
    cmd(SETA, 8'hD1, 8'h00, 32'h1000);
    rd(8'hD1, 32'h1000);
    mag_angle_i <= 10'h003;
    rd(8'hD1, 32'h10C8);
    cmd(SETA, 8'h8C, 8'h00, 32'h4);
    check(microstep_res_o, 4'h4);
    @(posedge clk_i);
    mag_angle_i <= 10'h023;
    rd(8'hD1, 32'h112C);
    cmd(SETA, 8'hD2, 8'h00, 32'h1);
    rd(8'hD2, 32'h1);
    mag_angle_i <= 10'h000;
    rd(8'hD2, 32'h0);
    rd(8'hD1, 32'h0);
    motor_pos_i <= 32'd100;
    cmd(SETA, 8'hD4, 8'h00, 32'd100);
    check(deviation_stop_o, 1'b0);
    motor_pos_i <= 32'd101;
    repeat (3) @(posedge clk_i);
    #1;
    check(deviation_stop_o, 1'b1);
    cmd(SETA, 8'hD4, 8'h00, 32'h0);
    repeat (2) @(posedge clk_i);
    #1;
    check(deviation_stop_o, 1'b0);
    motor_pos_i <= 32'h0;
    $display("internal encoder test done");
    cmd(SETA, 8'h8C, 8'h00, 32'h8);
    cmd(SETA, 8'hD9, 8'h00, 32'd51200);
    cmd(SETA, 8'hD8, 8'h00, 32'h5);
    i_axfe_far_model.quad(3);
    rd(8'hD8, 32'h8);
    i_axfe_far_model.quad(-5);
    rd(8'hD8, 32'h3);
    cmd(SETA, 8'hDA, 8'h00, 32'h2);
    repeat (2) @(posedge clk_i);
    #1;
    check(deviation_stop_o, 1'b1);
    cmd(SETA, 8'hDA, 8'h00, 32'h0);
    $display("external encoder test done");
    cmd(SETA, 8'hFE, 8'h00, 32'h1);
    cmd(axfe_pkg::rotate_left_cmd, 8'h00, 8'h00, 32'h10);
    check({r_ok, motion_valid_o}, 2'h0);
    i_axfe_far_model.pulse(1'b1);
    #1;
    check({step_o, dir_o}, 2'h3);
    cmd(SETA, 8'h8C, 8'h00, 32'h6);
    check({r_ok, microstep_res_o}, 5'h16);
    cmd(SETA, 8'hFE, 8'h00, 32'h0);
    cmd(axfe_pkg::move_to_position_cmd, 8'h00, 8'h00, 32'h1234);
    check({r_ok, motion_valid_o}, 2'h3);
    check(motion_value_o, 32'h1234);
    check(motion_op_o, axfe_pkg::move_to_position_cmd);
    $display("step direction test done");
    cmd(SETG, 8'h1B, 8'h02, 32'h1);
    check(r_ok, 1'b0);
    cmd(SETG, 8'h1B, 8'h03, 32'h1);
    cmd(SETG, 8'h1C, 8'h03, 32'h0);
    cmd(SETG, 8'h27, 8'h03, 32'h2);
    cmd(SETG, 8'h28, 8'h03, 32'h3);
    @(posedge clk_i);
    left_limit_i  <= 1'b1;
    right_limit_i <= 1'b1;
    gp_in_i       <= 3'h0;
    repeat (3) @(posedge clk_i);
    #1;
    check({event_valid_o, event_num_o}, 9'h11B);
    ack();
    check({event_valid_o, event_num_o}, 9'h127);
    ack();
    check(event_valid_o, 1'b0);
    for (int k = 0; k < 2; k++) begin
      gp_in_i[1] <= ~gp_in_i[1];
      repeat (3) @(posedge clk_i);
      #1;
      check({event_valid_o, event_num_o}, 9'h128);
      ack();
    end
    left_limit_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check(event_valid_o, 1'b0);
    $display("edge event test done");
    cmd(SETG, 8'h01, 8'h03, 32'h2);
    wait_ev(60);
    check({event_valid_o, event_num_o}, 9'h101);
    ack();
    wait_ev(60);
    check({event_valid_o, event_num_o}, 9'h101);
    check(cnt >= 12 && cnt <= 22, 1'b1);
    cmd(SETG, 8'h01, 8'h03, 32'h0);
    ack();
    repeat (30) @(posedge clk_i);
    #1;
    check(event_valid_o, 1'b0);
    $display("timer event test done");
    results();
  end
endmodule : tb_axfe_core
